// ---- verif/akus_bench.sv ----
`timescale 1ns/1ps
`include "akus_defs.svh"
module akus_bench;
    import akus_pkg::*;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, osc_in, osc_out, o0, e, prev_r;
    logic shaped_keying_input, io_update, sync_in, sync_clk_out;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [13:0] scale_factor;
    akus_mode_t mode;
    int num_errors, n_compared, n_adv, since_r, a0;
    akus_top #(.CNT_W(10)) dut_u (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .shaped_keying_input, .io_update, .sync_in, .osc_in,
        .sync_clk_out, .osc_out, .scale_factor, .mode);
    akus_ctrl_model ctrl_u (.clock, .io_update, .shaped_keying_input, .sync_in);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // a rising edge sooner than four cycles after the last one is an advance
    always @(posedge clock) begin
        prev_r <= sync_clk_out;
        osc_in <= ~osc_in;
        since_r <= since_r + 1;
        if (sync_clk_out === 1'b1 && prev_r === 1'b0) begin
            since_r <= 1;
            if (since_r < 4) n_adv <= n_adv + 1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) num_errors++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic st(input logic [1:0] m, input logic [13:0] s);
        apb(1'b0, `AKUS_OFF_STAT, 32'h0);
        chk(q & 32'h0030_3fff, {10'h0, m, 6'h0, s});
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #50000;
        num_errors++;
        wrap_up();
    end
    initial begin
        {rst, psel, penable, pwrite, osc_in, prev_r} = 6'h20;
        {paddr, pwdata, num_errors, n_compared, n_adv, since_r} = '0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rd(`AKUS_OFF_CW1, 32'h0);
        rd(`AKUS_OFF_CW2, 32'h0);
        rd(`AKUS_OFF_ASF, 32'h0);
        rd(`AKUS_OFF_ARR, 32'h0);
        st(AKUS_BYPASS, 14'h3fff);
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, `AKUS_OFF_CW2, 32'h0000_0800);
        rd(`AKUS_OFF_CW2, 32'h0000_0800);
        done("reset");
        apb(1'b1, `AKUS_OFF_ASF, 32'h0000_1234);
        apb(1'b1, `AKUS_OFF_CW1, 32'h0200_0000);
        st(AKUS_BYPASS, 14'h3fff);
        ctrl_u.strobe();
        st(AKUS_MANUAL, 14'h1234);
        done("manual");
        apb(1'b1, `AKUS_OFF_ARR, 32'h0000_0064);
        ctrl_u.key(1'b1);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `AKUS_OFF_ASF, {16'h0, c[1:0], 14'h3ff0});
            apb(1'b1, `AKUS_OFF_CW1, 32'h0200_0000);
            ctrl_u.strobe();
            apb(1'b1, `AKUS_OFF_CW1, 32'h0300_0000);
            ctrl_u.strobe();
            repeat (130) @(posedge clock);
            st(AKUS_AUTO, {10'(1 << c), 4'h0});
        end
        done("steps");
        apb(1'b1, `AKUS_OFF_ASF, 32'h0000_c800);
        apb(1'b1, `AKUS_OFF_ARR, 32'h0000_0002);
        ctrl_u.strobe();
        repeat (120) @(posedge clock);
        st(AKUS_AUTO, 14'h0802);
        ctrl_u.key(1'b0);
        repeat (60) @(posedge clock);
        st(AKUS_AUTO, 14'h0000);
        // strobes every 17 cycles keep reloading an 80-cycle timer
        apb(1'b1, `AKUS_OFF_ARR, 32'h0000_0050);
        apb(1'b1, `AKUS_OFF_CW1, 32'h0700_0000);
        ctrl_u.strobe();
        ctrl_u.key(1'b1);
        repeat (6) ctrl_u.strobe();
        st(AKUS_AUTO, 14'h0000);
        repeat (100) @(posedge clock);
        st(AKUS_AUTO, 14'h0080);
        apb(1'b1, `AKUS_OFF_CW1, 32'h0100_0000);
        ctrl_u.strobe();
        st(AKUS_BYPASS, 14'h3fff);
        done("auto");
        a0 = n_adv;
        repeat (40) @(posedge clock);
        chk(n_adv - a0, 0);
        apb(1'b1, `AKUS_OFF_CW1, 32'h0040_0000);
        repeat (12) @(posedge clock);
        chk(n_adv - a0, 1);
        rd(`AKUS_OFF_CW1, 32'h0);
        apb(1'b1, `AKUS_OFF_CW1, 32'h0040_0000);
        repeat (20) @(posedge clock);
        chk(n_adv - a0, 2);
        apb(1'b1, `AKUS_OFF_CW2, 32'h0000_0400);
        ctrl_u.strobe();
        a0 = n_adv;
        ctrl_u.sync_edge();
        repeat (8) @(posedge clock);
        chk(n_adv - a0, 1);
        rd(`AKUS_OFF_CW2, 32'h0000_0400);
        apb(1'b1, `AKUS_OFF_CW1, 32'h0080_0000);
        apb(1'b1, `AKUS_OFF_CW2, 32'h0000_0200);
        ctrl_u.strobe();
        ctrl_u.master_on <= 1'b1;
        repeat (100) @(posedge clock);
        a0 = n_adv;
        repeat (40) @(posedge clock);
        chk(n_adv - a0, 0);
        o0 = osc_out;
        @(posedge clock);
        chk({31'h0, osc_out ^ o0}, 32'h1);
        done("sync");
        wrap_up();
    end
endmodule
bind akus_top akus_top_asserts #(.CNT_W(CNT_W)) chk_u (.clock, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .shaped_keying_input, .io_update, .sync_in,
    .osc_in, .sync_clk_out, .osc_out, .scale_factor, .mode);

// ---- verif/akus_ctrl_model.sv ----
`timescale 1ns/1ps
module akus_ctrl_model (
    input wire logic clock,
    output logic io_update,
    output logic shaped_keying_input,
    output logic sync_in
);
    logic master_on;
    logic [1:0] div_r;
    initial begin
        io_update = 1'b0;
        shaped_keying_input = 1'b0;
        sync_in = 1'b0;
        master_on = 1'b0;
        div_r = 2'h0;
    end
    // free-running master sync clock, phase unrelated to the slave
    always @(posedge clock) begin
        div_r <= div_r + 2'h1;
        if (master_on) begin
            sync_in <= div_r[1];
        end
    end
    task automatic strobe();
        @(posedge clock);
        io_update <= 1'b1;
        repeat (8) @(posedge clock);
        io_update <= 1'b0;
        repeat (8) @(posedge clock);
    endtask
    task automatic key(input logic v);
        @(posedge clock);
        shaped_keying_input <= v;
    endtask
    task automatic sync_edge();
        @(posedge clock);
        sync_in <= 1'b1;
        repeat (4) @(posedge clock);
        sync_in <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
endmodule

// ---- verif/akus_top_asserts.sv ----
`timescale 1ns/1ps
module akus_top_asserts
    import akus_pkg::*;
#(
    parameter int CNT_W = 10
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic shaped_keying_input,
    input wire logic io_update,
    input wire logic sync_in,
    input wire logic osc_in,
    input wire logic sync_clk_out,
    input wire logic osc_out,
    input wire logic [13:0] scale_factor,
    input wire akus_pkg::akus_mode_t mode
);
    logic osc_en_r;
    logic [7:0] upd_age_r;
    // cycles since the strobe pin was last seen high, held at its top value
    // strobe may be short, so a fixed $past depth would miss it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            upd_age_r <= 8'hff;
        end else if (io_update) begin
            upd_age_r <= 8'h00;
        end else if (upd_age_r != 8'hff) begin
            upd_age_r <= upd_age_r + 8'h01;
        end
    end
    // sticky: the active copy may lag the buffer, so never cleared
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            osc_en_r <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == 8'h04 && pwdata[9]) begin
            osc_en_r <= 1'b1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_sync_high;
        $rose(sync_clk_out) |-> ##2 !sync_clk_out;
    endproperty
    a_sync_high: assert property (p_sync_high) else $error("sync clock high too long");
    property p_sync_low;
        $fell(sync_clk_out) |-> ##2 sync_clk_out;
    endproperty
    a_sync_low: assert property (p_sync_low) else $error("sync clock low too long");
    property p_wait;
        psel && !penable ##1 psel && penable |-> !pready ##1 pready;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer not after one wait");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_err;
        pslverr |-> pready && (pwrite || prdata == 32'h0);
    endproperty
    a_err: assert property (p_err) else $error("bad error response");
    property p_bypass;
        mode == AKUS_BYPASS && $past(mode) == AKUS_BYPASS |-> scale_factor == 14'h3fff;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass scale not full");
    property p_auto_fmt;
        mode == AKUS_AUTO && $past(mode) == AKUS_AUTO && $past(mode, 2) == AKUS_AUTO
            |-> scale_factor[3:0] == scale_factor[13:10];
    endproperty
    a_auto_fmt: assert property (p_auto_fmt) else $error("auto scale bad format");
    property p_osc;
        !osc_en_r |-> !osc_out;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator out before enable");
    property p_mode_upd;
        $changed(mode) |-> upd_age_r <= 8'h07;
    endproperty
    a_mode_upd: assert property (p_mode_upd) else $error("mode moved without update");
    property p_man_upd;
        $changed(scale_factor) && mode != AKUS_AUTO && $past(mode) != AKUS_AUTO
            |-> upd_age_r <= 8'h07;
    endproperty
    a_man_upd: assert property (p_man_upd) else $error("scale moved without update");
endmodule

// ---- verilog/akus_defs.svh ----
`ifndef AKUS_DEFS_SVH
`define AKUS_DEFS_SVH

// register byte addresses
`define AKUS_OFF_CW1 8'h00
`define AKUS_OFF_CW2 8'h04
`define AKUS_OFF_ASF 8'h08
`define AKUS_OFF_ARR 8'h0c
`define AKUS_OFF_STAT 8'h10

// control_word_one bit positions
`define AKUS_CW1_LOAD_TMR 26
`define AKUS_CW1_KEY_EN 25
`define AKUS_CW1_KEY_INT 24
`define AKUS_CW1_AUTO_SYNC 23
`define AKUS_CW1_SW_SYNC 22

// control_word_two bit positions
`define AKUS_CW2_HS_SYNC 11
`define AKUS_CW2_HW_SYNC 10
`define AKUS_CW2_XTAL_EN 9

// amplitude_scale_register fields
`define AKUS_ASF_STEP_LSB 14
`define AKUS_ASF_LIM_MSB 13

// reset values
`define AKUS_RST_CW1 5'h00
`define AKUS_RST_CW2 3'h0
`define AKUS_RST_ASF 16'h0000
`define AKUS_RST_ARR 8'h00

// full-scale multiplier code used while keying is bypassed
`define AKUS_FULL_SCALE 14'h3fff
// sync clock phase a slave aims for when its sync input rises
`define AKUS_ALIGN_PH 2'h2
// system clock cycles per sync clock cycle
`define AKUS_SYNC_DIV 4

`endif

// ---- verilog/akus_pkg.sv ----
package akus_pkg;
    typedef enum logic [1:0] {
        AKUS_BYPASS,
        AKUS_MANUAL,
        AKUS_AUTO
    } akus_mode_t;
endpackage

// ---- verilog/akus_ramp.sv ----
`timescale 1ns/1ps
module akus_ramp #(parameter int CNT_W = 10) (
    input wire logic clock,
    input wire logic rst,
    akus_ramp_if.ramp rif
);
    logic [7:0] timer_r;
    logic key_prev_r;
    logic auto_prev_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] step;
    logic [CNT_W:0] sum;
    logic tick;
    logic reload;

    assign step = CNT_W'(1) << rif.step_code; // R5
    assign tick = rif.auto_en & (timer_r <= 8'h01); // R7
    assign reload = tick | (rif.key_lvl != key_prev_r) // R9
        | rif.upd_load // R8
        | (rif.auto_en & ~auto_prev_r); // R10
    assign sum = {1'b0, cnt_r} + {1'b0, step};

    always_comb begin
        cnt_nxt = cnt_r;
        if (rif.key_lvl) begin // R3
            // clamp to the limit instead of wrapping
            cnt_nxt = (sum >= {1'b0, rif.limit}) ? rif.limit : sum[CNT_W-1:0]; // R6 R23
        end else if (cnt_r < step) begin
            cnt_nxt = '0; // R23
        end else begin
            cnt_nxt = cnt_r - step;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timer_r <= 8'h00;
            key_prev_r <= 1'b0;
            auto_prev_r <= 1'b0;
        end else begin
            key_prev_r <= rif.key_lvl;
            auto_prev_r <= rif.auto_en;
            if (!rif.auto_en || reload) begin
                timer_r <= rif.rate; // R7
            end else begin
                timer_r <= timer_r - 8'h01;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (!rif.auto_en) begin
            cnt_r <= '0;
        end else if (tick) begin
            cnt_r <= cnt_nxt; // R2
        end
    end

    assign rif.scale = cnt_r;
endmodule

// ---- verilog/akus_ramp_if.sv ----
`timescale 1ns/1ps
interface akus_ramp_if #(parameter int CNT_W = 10);
    logic auto_en;
    logic key_lvl;
    logic upd_load;
    logic [7:0] rate;
    logic [1:0] step_code;
    logic [CNT_W-1:0] limit;
    logic [CNT_W-1:0] scale;
    modport ctrl (output auto_en, key_lvl, upd_load, rate, step_code, limit, input scale);
    modport ramp (input auto_en, key_lvl, upd_load, rate, step_code, limit, output scale);
endinterface

// ---- verilog/akus_sync_gen.sv ----
`timescale 1ns/1ps
`include "akus_defs.svh"
module akus_sync_gen (
    input wire logic clock,
    input wire logic rst,
    input wire logic manual_adv,
    input wire logic hw_en,
    input wire logic auto_en,
    input wire logic sync_in_rise,
    output logic sync_clk,
    output logic rise,
    output logic [1:0] phase
);
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;
    logic adv;
    logic sync_clk_r;
    logic rise_r;

    // auto mode nudges one cycle per master edge until phases agree
    assign adv = manual_adv | (hw_en & sync_in_rise) // R18 R19
        | (auto_en & sync_in_rise & (phase_r != `AKUS_ALIGN_PH)); // R16
    // an advance skips one phase step, pulling the rising edge earlier
    assign phase_nxt = adv ? phase_r + 2'h2 : phase_r + 2'h1; // R12

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_r <= 2'h0;
            sync_clk_r <= 1'b0;
            rise_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            sync_clk_r <= ~phase_nxt[1];
            rise_r <= ~phase_nxt[1] & ~sync_clk_r;
        end
    end

    assign sync_clk = sync_clk_r;
    assign rise = rise_r;
    assign phase = phase_r;
endmodule

// ---- verilog/akus_top.sv ----
// Behaviour
// R1 - auto keying needs enable and internal select
// R2 - auto scale from 10-bit paced counter
// R3 - count up on keying high, down low
// R4 - scale factor unsigned, zero to full scale
// R5 - step code selects 1, 2, 4, 8
// R6 - ramp limited by amplitude scale value
// R7 - timer down-counts, reloads at one, repeats
// R8 - load bit lets update reload timer
// R9 - keying pin change reloads timer
// R10 - entering auto mode reloads timer
// R11 - manual mode uses amplitude register directly
// R12 - sync clock is system clock over four
// R13 - update strobe sampled on sync rising edge
// R14 - strobe edge copies buffers to active registers
// R15 - controller keeps strobe low one sync cycle
// R16 - auto sync slews phase to sync input
// R17 - software sets speed bit above 250 MSPS
// R18 - software sync bit advances once, self-clears
// R19 - hardware sync: input edges advance phase
// R20 - system shares clock and strobe edge
// R21 - oscillator pin static until enabled
// R22 - keying disabled bypasses scaling entirely
// R23 - scale saturates, never wraps
`timescale 1ns/1ps
`include "akus_defs.svh"
module akus_top #(
    parameter int CNT_W = 10
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic shaped_keying_input,
    input wire logic io_update,
    input wire logic sync_in,
    input wire logic osc_in,
    output logic sync_clk_out,
    output logic osc_out,
    output logic [13:0] scale_factor,
    output akus_pkg::akus_mode_t mode
);
    import akus_pkg::*;

    // buffered copies, written over the bus
    logic [4:0] cw1_buf_r;
    logic [2:0] cw2_buf_r;
    logic [15:0] asf_buf_r;
    logic [7:0] arr_buf_r;
    // active copies, loaded by the update pulse
    logic [4:0] cw1_r;
    logic [2:0] cw2_r;
    logic [15:0] asf_r;
    logic [7:0] arr_r;

    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic access;
    logic wr_take;
    logic mapped;
    logic [31:0] rd_mux;
    logic sw_sync_r;

    logic [1:0] key_sync_r;
    logic [1:0] upd_sync_r;
    logic [1:0] sin_sync_r;
    logic [1:0] osc_sync_r;
    logic sin_prev_r;
    logic sin_rise;
    logic upd_smp_r;
    logic upd_prev_r;
    logic upd_pulse;

    logic sync_clk_w;
    logic sync_rise;
    logic [1:0] sync_phase;
    logic sync_clk_out_r;
    logic osc_out_r;
    logic [13:0] scale_r;
    akus_mode_t mode_r;
    akus_mode_t mode_nxt;

    akus_ramp_if #(.CNT_W(CNT_W)) rif ();

    // apb slave: one wait state, then pready for one cycle
    assign access = psel & penable;
    assign wr_take = access & pwrite & pready_r;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        if (paddr == `AKUS_OFF_CW1) begin
            rd_mux[`AKUS_CW1_LOAD_TMR:`AKUS_CW1_SW_SYNC] = cw1_buf_r;
        end else if (paddr == `AKUS_OFF_CW2) begin
            rd_mux[`AKUS_CW2_HS_SYNC:`AKUS_CW2_XTAL_EN] = cw2_buf_r;
        end else if (paddr == `AKUS_OFF_ASF) begin
            rd_mux[15:0] = asf_buf_r;
        end else if (paddr == `AKUS_OFF_ARR) begin
            rd_mux[7:0] = arr_buf_r;
        end else if (paddr == `AKUS_OFF_STAT) begin
            rd_mux[13:0] = scale_r;
            rd_mux[17:16] = sync_phase;
            rd_mux[21:20] = mode_r;
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= access & ~pready_r;
            pslverr_r <= access & ~pready_r & ~mapped;
            if (access && !pready_r && !pwrite) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // the sync bit is never stored, so it always reads back as zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sw_sync_r <= 1'b0;
        end else begin
            sw_sync_r <= wr_take && paddr == `AKUS_OFF_CW1
                && pwdata[`AKUS_CW1_SW_SYNC]; // R18
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cw1_buf_r <= `AKUS_RST_CW1;
            cw2_buf_r <= `AKUS_RST_CW2;
            asf_buf_r <= `AKUS_RST_ASF;
            arr_buf_r <= `AKUS_RST_ARR;
        end else if (wr_take) begin
            if (paddr == `AKUS_OFF_CW1) begin
                cw1_buf_r <= {pwdata[`AKUS_CW1_LOAD_TMR:`AKUS_CW1_AUTO_SYNC], 1'b0};
            end else if (paddr == `AKUS_OFF_CW2) begin
                cw2_buf_r <= pwdata[`AKUS_CW2_HS_SYNC:`AKUS_CW2_XTAL_EN];
            end else if (paddr == `AKUS_OFF_ASF) begin
                asf_buf_r <= pwdata[15:0];
            end else if (paddr == `AKUS_OFF_ARR) begin
                arr_buf_r <= pwdata[7:0];
            end
        end
    end

    // pin synchronisers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            key_sync_r <= 2'h0;
            upd_sync_r <= 2'h0;
            sin_sync_r <= 2'h0;
            osc_sync_r <= 2'h0;
            sin_prev_r <= 1'b0;
        end else begin
            key_sync_r <= {key_sync_r[0], shaped_keying_input};
            upd_sync_r <= {upd_sync_r[0], io_update};
            sin_sync_r <= {sin_sync_r[0], sync_in};
            osc_sync_r <= {osc_sync_r[0], osc_in};
            sin_prev_r <= sin_sync_r[1];
        end
    end

    assign sin_rise = sin_sync_r[1] & ~sin_prev_r;

    akus_sync_gen u_sync (
        .clock(clock),
        .rst(rst),
        .manual_adv(sw_sync_r),
        .hw_en(cw2_r[`AKUS_CW2_HW_SYNC - `AKUS_CW2_XTAL_EN]), // R19
        .auto_en(cw1_r[`AKUS_CW1_AUTO_SYNC - `AKUS_CW1_SW_SYNC]), // R16
        .sync_in_rise(sin_rise),
        .sync_clk(sync_clk_w),
        .rise(sync_rise),
        .phase(sync_phase)
    );

    // strobe is only looked at on sync clock rising edges
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            upd_smp_r <= 1'b0;
            upd_prev_r <= 1'b0;
        end else if (sync_rise) begin
            upd_smp_r <= upd_sync_r[1]; // R13
            upd_prev_r <= upd_smp_r;
        end
    end

    // a held-high strobe yields one pulse; a new one needs a low sample
    assign upd_pulse = sync_rise & upd_smp_r & ~upd_prev_r; // R14 R15

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cw1_r <= `AKUS_RST_CW1;
            cw2_r <= `AKUS_RST_CW2;
            asf_r <= `AKUS_RST_ASF;
            arr_r <= `AKUS_RST_ARR;
        end else if (upd_pulse) begin
            cw1_r <= cw1_buf_r; // R14
            cw2_r <= cw2_buf_r;
            asf_r <= asf_buf_r;
            arr_r <= arr_buf_r;
        end
    end

    always_comb begin
        if (!cw1_r[`AKUS_CW1_KEY_EN - `AKUS_CW1_SW_SYNC]) begin
            mode_nxt = AKUS_BYPASS; // R22
        end else if (cw1_r[`AKUS_CW1_KEY_INT - `AKUS_CW1_SW_SYNC]) begin
            mode_nxt = AKUS_AUTO; // R1
        end else begin
            mode_nxt = AKUS_MANUAL; // R11
        end
    end

    assign rif.auto_en = (mode_nxt == AKUS_AUTO); // R1
    assign rif.key_lvl = key_sync_r[1];
    assign rif.upd_load = upd_pulse & cw1_r[`AKUS_CW1_LOAD_TMR - `AKUS_CW1_SW_SYNC]; // R8
    assign rif.rate = arr_r;
    assign rif.step_code = asf_r[15:`AKUS_ASF_STEP_LSB];
    // limit compares against the top bits of the 14-bit scale value
    assign rif.limit = asf_r[`AKUS_ASF_LIM_MSB -: CNT_W]; // R6

    akus_ramp #(.CNT_W(CNT_W)) u_ramp (
        .clock(clock),
        .rst(rst),
        .rif(rif)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_r <= AKUS_BYPASS;
            scale_r <= `AKUS_FULL_SCALE;
        end else begin
            mode_r <= mode_nxt;
            case (mode_nxt)
                AKUS_AUTO: begin
                    // widen by repeating msbs so all-ones reaches full scale
                    scale_r <= {rif.scale, rif.scale[CNT_W-1 -: 14 - CNT_W]}; // R4
                end
                AKUS_MANUAL: begin
                    scale_r <= asf_r[`AKUS_ASF_LIM_MSB:0]; // R11
                end
                default: begin
                    scale_r <= `AKUS_FULL_SCALE; // R22
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_clk_out_r <= 1'b0;
            osc_out_r <= 1'b0;
        end else begin
            sync_clk_out_r <= sync_clk_w; // R12
            osc_out_r <= osc_sync_r[1] & cw2_r[0]; // R21
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sync_clk_out = sync_clk_out_r;
    assign osc_out = osc_out_r;
    assign scale_factor = scale_r;
    assign mode = mode_r;
endmodule
